// ==== verilog/ubae_regs.svh ====
// register offsets, field positions, reset values and timing counts of the serial port
`ifndef UBAE_REGS_SVH
`define UBAE_REGS_SVH
`define UBAE_OFF_CTRL    12'h000
`define UBAE_OFF_BAUD    12'h004
`define UBAE_OFF_STAT    12'h008
`define UBAE_OFF_RXBUF   12'h00c
`define UBAE_OFF_TXBUF   12'h010
`define UBAE_OFF_IRDA    12'h014
`define UBAE_C_SWRST     0
`define UBAE_C_MODE      2:1
`define UBAE_C_PEN       3
`define UBAE_C_PEVEN     4
`define UBAE_C_MSB       5
`define UBAE_C_SEVEN     6
`define UBAE_C_SPB       7
`define UBAE_C_BRKIE     8
`define UBAE_C_RXEIE     9
`define UBAE_C_DORM      10
`define UBAE_C_TXBRK     11
`define UBAE_C_ABDEN     12
`define UBAE_C_DELIM     14:13
`define UBAE_I_EN        0
`define UBAE_I_TXCLK     1
`define UBAE_I_TXPL      7:2
`define UBAE_I_RXPL      8
`define UBAE_I_RXFE      9
`define UBAE_I_RXFL      15:10
`define UBAE_CTRL_RST    16'h0001
`define UBAE_PRE_RST     16'h0010
`define UBAE_MODE_AUTO   2'h3
`define UBAE_OS_LAST     4'hf
`define UBAE_VOTE_A      4'h7
`define UBAE_VOTE_B      4'h9
`define UBAE_BRK_MIN     5'h0b
`define UBAE_BRK_TMO     5'h15
`define UBAE_TX_BRK_LAST 4'hc
`define UBAE_SYNC_MAX    15'h7fff
`define UBAE_SYNC_FALLS  3'h5
`define UBAE_SYNC_WAIT   3'h6
`define UBAE_IR_HOLD     5'h10
`define UBAE_CLK_HZ      50000000
`define UBAE_DEGLITCH_NS 150
`define UBAE_DEGLITCH_CYC ((`UBAE_DEGLITCH_NS * (`UBAE_CLK_HZ / 1000000) + 999) / 1000)
`endif

// ==== verilog/ubae_pkg.sv ====
// types shared by the serial port: bus carriers, state enums and the state record
package ubae_pkg;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } ubae_apb_req_t;
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } ubae_apb_rsp_t;
  typedef enum logic [2:0] {
    rx_idle = 3'b000, rx_start = 3'b001, rx_data = 3'b010, rx_brk = 3'b011, rx_sync = 3'b100
  } ubae_rx_st_t;
  typedef enum logic [1:0] {
    tx_idle = 2'b00, tx_brk = 2'b01, tx_delim = 2'b10, tx_data = 2'b11
  } ubae_tx_st_t;
  typedef struct packed {
    logic [15:0]   ctrl;
    logic [15:0]   irda;
    logic [15:0]   prescaler;
    logic [7:0]    modulation;
    logic          fe, pe, oe, brk, err, bto, sto, rx_irq, tx_irq;
    logic          loaded_after_stat, pass_next;
    logic [7:0]    rx_buffer;
    logic [7:0]    tx_buffer;
    logic [15:0]   pre_cnt;
    ubae_rx_st_t   rx_st;
    logic [3:0]    rx_os, rx_b, deg_cnt;
    logic [1:0]    vote;
    logic [7:0]    rx_shift;
    logic          rx_zero, rx_fe, rx_pe, rx_par, rx_prev;
    logic [4:0]    low_bits, ir_hold;
    logic [14:0]   sync_cnt;
    logic [2:0]    falls;
    logic [5:0]    ir_cnt;
    ubae_tx_st_t   tx_st;
    logic [3:0]    tx_os, tx_bits;
    logic [11:0]   tx_shift;
    logic [6:0]    ir_pulse;
    logic          tx_out;
    ubae_apb_rsp_t rsp;
  } ubae_state_t;
endpackage

// ==== verilog/ubae_core.sv ====
// serial port with break, auto-baud, infrared coding and receive error flags
//
// Local design decisions: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`include "ubae_regs.svh"
// What this block does
// - modes 00-10: all-low character flags break
// - transmit break, bit cleared as the break starts
// - mode 11: break after 11 zeros, timeout past 21
// - auto-baud times synch byte into prescaler
// - measurement counter saturates, sets synch timeout
// - mode 11 dormant: deliver only character after break/synch
// - break interrupt enable raises receive flag
// - hardware never alters the dormant bit
// - dormant clear: every error-free character sets receive flag
// - mode 11: 13-bit break, delimiter, then the buffered character
// - infrared pulse per zero, programmed length
// - decoder pulse polarity follows polarity setting
// - digital filter drops pulses not above length
// - deglitch, then majority vote start and data
// - low stop bit sets framing error
// - parity mismatch sets parity error
// - load before read sets overrun
// - summary flag follows framing, parity, overrun
// - error enable decides loading bad characters
// - flags clear by software or buffer read
module ubae_core (
  input  wire logic                   clk_in,
  input  wire logic                   reset_n_in,
  input  wire ubae_pkg::ubae_apb_req_t apb_in,
  output ubae_pkg::ubae_apb_rsp_t     apb_out,
  input  wire logic                   rx_line_in,
  output logic                        tx_line_out
);
  import ubae_pkg::*;

  ubae_state_t q;
  ubae_state_t d;
  logic [15:0] pre_eff;
  logic        os_tick;
  logic        half_tick;
  logic        ir_act;
  logic        rx_dec;
  logic        mode11;
  logic [3:0]  nd;
  logic [3:0]  last_bit;
  logic        bit_end;
  logic        tx_end;
  logic        vbit;
  logic        a_req;
  logic        a_done;
  logic [7:0]  rx_word;
  logic [10:0] stat;

  assign pre_eff   = (q.prescaler == 16'h0000) ? 16'h0001 : q.prescaler;
  assign os_tick   = q.pre_cnt == 16'h0000;
  assign half_tick = os_tick || (q.pre_cnt == {1'b0, pre_eff[15:1]});
  assign ir_act    = q.irda[`UBAE_I_RXPL] ? ~rx_line_in : rx_line_in;
  assign rx_dec    = q.irda[`UBAE_I_EN] ? (q.ir_hold == 5'h00) : rx_line_in;
  assign mode11    = q.ctrl[`UBAE_C_MODE] == `UBAE_MODE_AUTO;
  assign nd        = q.ctrl[`UBAE_C_SEVEN] ? 4'h7 : 4'h8;
  assign last_bit  = nd + {3'h0, q.ctrl[`UBAE_C_PEN]} + 4'h1 + {3'h0, q.ctrl[`UBAE_C_SPB]};
  assign bit_end   = os_tick && (q.rx_os == `UBAE_OS_LAST);
  assign tx_end    = os_tick && (q.tx_os == `UBAE_OS_LAST);
  assign vbit      = q.vote[1];
  assign a_req     = apb_in.psel && apb_in.penable;
  assign a_done    = a_req && q.rsp.pready;
  assign rx_word   = q.ctrl[`UBAE_C_MSB] ? (q.ctrl[`UBAE_C_SEVEN] ? {1'b0, q.rx_shift[6:0]} : q.rx_shift)
                                        : (q.ctrl[`UBAE_C_SEVEN] ? {1'b0, q.rx_shift[7:1]} : q.rx_shift);
  assign stat      = {q.tx_st != tx_idle, q.rx_st != rx_idle, q.tx_irq, q.rx_irq, q.sto, q.bto,
                      q.err, q.brk, q.oe, q.pe, q.fe};
  assign apb_out     = q.rsp;
  assign tx_line_out = q.tx_out;

  always_comb begin
    logic [7:0]  rev;
    logic [7:0]  dord;
    logic        par;
    logic [11:0] fr;
    logic        dlv;
    logic        dlv_brk;
    logic        dfe;
    logic        dpe;
    logic        ubit;
    logic        ok;
    logic        ovr;
    logic        fall;
    d       = q;
    rev     = 8'h00;
    dord    = 8'h00;
    par     = 1'b0;
    fr      = 12'hfff;
    dlv     = 1'b0;
    dlv_brk = 1'b0;
    dfe     = 1'b0;
    dpe     = 1'b0;
    ubit    = 1'b1;
    ok      = 1'b0;
    ovr     = 1'b0;
    fall    = q.rx_prev && !rx_dec;
    d.rx_prev = rx_dec;
    d.pre_cnt = os_tick ? pre_eff - 16'h0001 : q.pre_cnt - 16'h0001;

    // bus: answer one cycle into the access phase, commit at the edge that sees pready
    if (a_req && !q.rsp.pready) begin
      d.rsp.pready  = 1'b1;
      d.rsp.pslverr = 1'b0;
      d.rsp.prdata  = 32'h0000_0000;
      if (apb_in.paddr == `UBAE_OFF_CTRL) begin
        d.rsp.prdata = {16'h0000, q.ctrl};
      end else if (apb_in.paddr == `UBAE_OFF_BAUD) begin
        d.rsp.prdata = {8'h00, q.modulation, q.prescaler};
      end else if (apb_in.paddr == `UBAE_OFF_STAT) begin
        d.rsp.prdata = {21'h00_0000, stat};
      end else if (apb_in.paddr == `UBAE_OFF_RXBUF) begin
        d.rsp.prdata = {24'h00_0000, q.rx_buffer};
      end else if (apb_in.paddr == `UBAE_OFF_TXBUF) begin
        d.rsp.prdata = {24'h00_0000, q.tx_buffer};
      end else if (apb_in.paddr == `UBAE_OFF_IRDA) begin
        d.rsp.prdata = {16'h0000, q.irda};
      end else begin
        d.rsp.pslverr = 1'b1;
      end
    end else if (a_done) begin
      d.rsp.pready  = 1'b0;
      d.rsp.pslverr = 1'b0;
      if (apb_in.pwrite) begin
        if (apb_in.paddr == `UBAE_OFF_CTRL) begin
          d.ctrl = apb_in.pwdata[15:0];
        end else if (apb_in.paddr == `UBAE_OFF_BAUD) begin
          d.prescaler  = apb_in.pwdata[15:0];
          d.modulation = apb_in.pwdata[23:16];
        end else if (apb_in.paddr == `UBAE_OFF_STAT) begin
          // write one to clear; overrun only goes away through a buffer read or soft reset
          d.fe     = q.fe & ~apb_in.pwdata[0];
          d.pe     = q.pe & ~apb_in.pwdata[1];
          d.brk    = q.brk & ~apb_in.pwdata[3];
          d.err    = q.err & ~apb_in.pwdata[4];
          d.bto    = q.bto & ~apb_in.pwdata[5];
          d.sto    = q.sto & ~apb_in.pwdata[6];
          d.rx_irq = q.rx_irq & ~apb_in.pwdata[7];
        end else if (apb_in.paddr == `UBAE_OFF_TXBUF) begin
          if (q.tx_irq) begin
            d.tx_buffer = apb_in.pwdata[7:0];
            d.tx_irq    = 1'b0;
          end
        end else if (apb_in.paddr == `UBAE_OFF_IRDA) begin
          d.irda = apb_in.pwdata[15:0];
        end
      end else if (apb_in.paddr == `UBAE_OFF_STAT) begin
        d.loaded_after_stat = 1'b0;
      end else if (apb_in.paddr == `UBAE_OFF_RXBUF) begin
        d.fe     = 1'b0;
        d.pe     = 1'b0;
        d.brk    = 1'b0;
        d.err    = 1'b0;
        d.rx_irq = 1'b0;
        // overrun survives when the buffer was refilled after the status read
        if (!q.loaded_after_stat) begin
          d.oe = 1'b0;
        end
      end
    end

    // infrared decoder: a qualified pulse becomes a zero of about one bit
    d.ir_cnt = ir_act ? ((q.ir_cnt == 6'h3f) ? q.ir_cnt : q.ir_cnt + 6'h01) : 6'h00;
    if (ir_act && ({1'b0, q.ir_cnt} == (q.irda[`UBAE_I_RXFE] ? {1'b0, q.irda[`UBAE_I_RXFL]} + 7'h01 : 7'h00))) begin
      d.ir_hold = `UBAE_IR_HOLD;
    end else if (os_tick && (q.ir_hold != 5'h00)) begin
      d.ir_hold = q.ir_hold - 5'h01;
    end

    // receiver
    case (q.rx_st)
      rx_idle: begin
        if (!rx_dec) begin
          d.deg_cnt = q.deg_cnt + 4'h1;
          if (q.deg_cnt == 4'(`UBAE_DEGLITCH_CYC - 1)) begin
            d.rx_st   = rx_start;
            d.deg_cnt = 4'h0;
            d.rx_os   = 4'h0;
            d.rx_b    = 4'h0;
            d.vote    = 2'h0;
            d.rx_zero = 1'b1;
            d.rx_fe   = 1'b0;
            d.rx_pe   = 1'b0;
            d.rx_par  = 1'b0;
          end
        end else begin
          d.deg_cnt = 4'h0;
        end
      end
      rx_start, rx_data, rx_brk: begin
        if (os_tick) begin
          d.rx_os = q.rx_os + 4'h1;
          if ((q.rx_os >= `UBAE_VOTE_A) && (q.rx_os <= `UBAE_VOTE_B)) begin
            d.vote = q.vote + {1'b0, rx_dec};
          end
        end
        if (bit_end) begin
          d.vote = 2'h0;
          d.rx_b = q.rx_b + 4'h1;
          if (q.rx_st == rx_start) begin
            d.rx_st = vbit ? rx_idle : rx_data;
          end else if (q.rx_st == rx_brk) begin
            if (!vbit) begin
              d.low_bits = (q.low_bits == 5'h1f) ? q.low_bits : q.low_bits + 5'h01;
            end else if (q.low_bits >= `UBAE_BRK_MIN) begin
              d.brk       = 1'b1;
              d.bto       = q.bto | (q.low_bits > `UBAE_BRK_TMO);
              d.pass_next = 1'b1;
              d.rx_irq    = d.rx_irq | q.ctrl[`UBAE_C_BRKIE];
              d.rx_st     = rx_sync;
              d.falls     = 3'h0;
              d.sync_cnt  = 15'h0000;
            end else begin
              d.rx_st = rx_idle;
              dlv     = 1'b1;
              dfe     = 1'b1;
            end
          end else begin
            if (q.rx_b <= nd) begin
              d.rx_shift = q.ctrl[`UBAE_C_MSB] ? {q.rx_shift[6:0], vbit} : {vbit, q.rx_shift[7:1]};
              d.rx_par   = q.rx_par ^ vbit;
            end else if (q.ctrl[`UBAE_C_PEN] && (q.rx_b == nd + 4'h1)) begin
              d.rx_pe = vbit != (q.ctrl[`UBAE_C_PEVEN] ? q.rx_par : ~q.rx_par);
            end else begin
              d.rx_fe = q.rx_fe | ~vbit;
            end
            d.rx_zero = q.rx_zero & ~vbit;
            if (q.rx_b == last_bit) begin
              if (mode11 && d.rx_zero) begin
                d.rx_st    = rx_brk;
                d.low_bits = {1'b0, last_bit} + 5'h01;
              end else begin
                d.rx_st = rx_idle;
                dlv     = 1'b1;
                dlv_brk = !mode11 && d.rx_zero;
                dfe     = d.rx_fe;
                dpe     = d.rx_pe;
              end
            end
          end
        end
      end
      rx_sync: begin
        // span from first to fifth falling edge of the synch byte is eight bits
        if ((q.falls != 3'h0) && (q.falls < `UBAE_SYNC_FALLS)) begin
          if (q.sync_cnt == `UBAE_SYNC_MAX) begin
            d.sto   = 1'b1;
            d.falls = `UBAE_SYNC_WAIT;
          end else begin
            d.sync_cnt = q.sync_cnt + 15'h0001;
          end
        end
        if (fall && (q.falls < `UBAE_SYNC_FALLS) && (d.falls != `UBAE_SYNC_WAIT)) begin
          d.falls = q.falls + 3'h1;
          if (q.falls == `UBAE_SYNC_FALLS - 3'h1) begin
            d.falls = `UBAE_SYNC_WAIT;
            if (q.ctrl[`UBAE_C_ABDEN]) begin
              // next count includes the cycle of the last fall itself
              d.prescaler  = {8'h00, d.sync_cnt[14:7]};
              d.modulation = {4'h0, d.sync_cnt[6:3]};
            end
          end
        end
        if ((q.falls == `UBAE_SYNC_WAIT) && rx_dec) begin
          d.rx_st = rx_idle;
        end
      end
      default: d.rx_st = rx_idle;
    endcase

    // delivery of a finished character
    if (dlv) begin
      // a break/synch raises the receive flag with no character behind it
      ovr = d.rx_irq && !q.pass_next;
      if (dlv_brk) begin
        d.brk = 1'b1;
        d.fe  = 1'b1;
        d.err = 1'b1;
        if (q.ctrl[`UBAE_C_BRKIE]) begin
          d.rx_buffer = 8'h00;
          d.rx_irq    = 1'b1;
        end
      end else begin
        ok = !mode11 || !q.ctrl[`UBAE_C_DORM] || q.pass_next;
        if (ok) begin
          d.pass_next = 1'b0;
          if (!(dfe || dpe) || q.ctrl[`UBAE_C_RXEIE]) begin
            d.oe                = d.oe | ovr;
            d.fe                = d.fe | dfe;
            d.pe                = d.pe | dpe;
            d.err               = d.err | dfe | dpe | ovr;
            d.rx_buffer         = dfe && !dpe && (rx_word == 8'h00) ? 8'h00 : rx_word;
            d.rx_irq            = 1'b1;
            d.loaded_after_stat = 1'b1;
          end
        end
      end
    end

    // transmitter
    if (os_tick && (q.tx_st != tx_idle)) begin
      d.tx_os = q.tx_os + 4'h1;
    end
    case (q.tx_st)
      tx_idle: begin
        ubit = 1'b1;
        if (!q.tx_irq) begin
          for (int i = 0; i < 8; i++) begin
            rev[i] = q.tx_buffer[7 - i];
          end
          dord = q.ctrl[`UBAE_C_MSB] ? (q.ctrl[`UBAE_C_SEVEN] ? rev >> 1 : rev) : q.tx_buffer;
          par  = ^(dord & (q.ctrl[`UBAE_C_SEVEN] ? 8'h7f : 8'hff));
          fr[0] = 1'b0;
          for (int i = 0; i < 8; i++) begin
            if (4'(i) < nd) begin
              fr[i + 1] = dord[i];
            end
          end
          if (q.ctrl[`UBAE_C_PEN]) begin
            fr[nd + 4'h1] = q.ctrl[`UBAE_C_PEVEN] ? par : ~par;
          end
          d.tx_irq          = 1'b1;
          d.tx_os           = 4'h0;
          d.tx_bits         = 4'h0;
          d.tx_shift        = (q.ctrl[`UBAE_C_TXBRK] && !mode11) ? 12'h000 : fr;
          d.tx_st           = (q.ctrl[`UBAE_C_TXBRK] && mode11) ? tx_brk : tx_data;
          d.ctrl[`UBAE_C_TXBRK] = 1'b0;
        end
      end
      tx_brk: begin
        ubit = 1'b0;
        if (tx_end) begin
          d.tx_bits = q.tx_bits + 4'h1;
          if (q.tx_bits == `UBAE_TX_BRK_LAST) begin
            d.tx_st   = tx_delim;
            d.tx_bits = 4'h0;
          end
        end
      end
      tx_delim: begin
        ubit = 1'b1;
        if (tx_end) begin
          d.tx_bits = q.tx_bits + 4'h1;
          if (q.tx_bits == {2'h0, q.ctrl[`UBAE_C_DELIM]}) begin
            d.tx_st   = tx_data;
            d.tx_bits = 4'h0;
          end
        end
      end
      tx_data: begin
        ubit = q.tx_shift[0];
        if (tx_end) begin
          d.tx_shift = {1'b1, q.tx_shift[11:1]};
          d.tx_bits  = q.tx_bits + 4'h1;
          if (q.tx_bits == last_bit) begin
            d.tx_st = tx_idle;
          end
        end
      end
      default: d.tx_st = tx_idle;
    endcase

    // infrared encoder counts half periods; the fast clock has no half edge, so it steps by two
    if (q.ir_pulse != 7'h00) begin
      if (q.irda[`UBAE_I_TXCLK]) begin
        d.ir_pulse = half_tick ? q.ir_pulse - 7'h01 : q.ir_pulse;
      end else begin
        d.ir_pulse = (q.ir_pulse >= 7'h02) ? q.ir_pulse - 7'h02 : 7'h00;
      end
    end
    if (os_tick && (q.tx_os == 4'h0) && (q.tx_st != tx_idle) && !ubit) begin
      d.ir_pulse = {1'b0, q.irda[`UBAE_I_TXPL]} + 7'h01;
    end
    d.tx_out = q.irda[`UBAE_I_EN] ? (q.ir_pulse != 7'h00) : ubit;

    // soft reset holds flags and both engines idle
    if (d.ctrl[`UBAE_C_SWRST]) begin
      d.fe        = 1'b0;
      d.pe        = 1'b0;
      d.oe        = 1'b0;
      d.brk       = 1'b0;
      d.err       = 1'b0;
      d.bto       = 1'b0;
      d.sto       = 1'b0;
      d.rx_irq    = 1'b0;
      d.tx_irq    = 1'b1;
      d.pass_next = 1'b0;
      d.rx_st     = rx_idle;
      d.tx_st     = tx_idle;
      d.ir_pulse  = 7'h00;
      d.tx_out    = ~d.irda[`UBAE_I_EN];
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      q           <= '0;
      q.ctrl      <= `UBAE_CTRL_RST;
      q.prescaler <= `UBAE_PRE_RST;
      q.tx_irq    <= 1'b1;
      q.tx_out    <= 1'b1;
      q.rx_prev   <= 1'b1;
    end else begin
      q <= d;
    end
  end
endmodule

// ==== test/ubae_core_asserts.sv ====
// bus and dormant-bit checker for the serial port
`timescale 1ns/100ps
`include "ubae_regs.svh"
module ubae_core_chk (
  input wire logic                    clk_in,
  input wire logic                    reset_n_in,
  input wire ubae_pkg::ubae_apb_req_t apb_in,
  input wire ubae_pkg::ubae_apb_rsp_t apb_out,
  input wire logic                    rx_line_in,
  input wire logic                    tx_line_out
);
  import ubae_pkg::*;
  logic done;
  logic rd;
  logic mapped;
  logic dorm_q;
  logic dorm_d;
  assign done   = apb_in.psel && apb_in.penable && apb_out.pready;
  assign rd     = done && !apb_in.pwrite;
  assign mapped = apb_in.paddr <= `UBAE_OFF_IRDA && apb_in.paddr[1:0] == 2'b00;
  // software's copy of dormant: hardware must never move it
  assign dorm_d = (done && apb_in.pwrite && apb_in.paddr == `UBAE_OFF_CTRL) ? apb_in.pwdata[`UBAE_C_DORM] : dorm_q;
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      dorm_q <= 1'b0;
    end else begin
      dorm_q <= dorm_d;
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  sequence s_waiting;
    apb_in.psel && apb_in.penable && !apb_out.pready;
  endsequence
  sequence s_answer;
    apb_out.pready ##1 !apb_out.pready;
  endsequence
  a_one_wait_state: assert property (s_waiting |=> s_answer)
    else $error("answer not one cycle after access");
  a_ready_in_access: assert property (apb_out.pready |-> apb_in.psel && apb_in.penable)
    else $error("ready outside access phase");
  a_unmapped_refused: assert property (done && !mapped |-> apb_out.pslverr)
    else $error("unmapped access not refused");
  a_mapped_accepted: assert property (done && mapped |-> !apb_out.pslverr)
    else $error("mapped access refused");
  a_refused_read_zero: assert property (rd && apb_out.pslverr |-> apb_out.prdata == 32'h0000_0000)
    else $error("refused read not zero");
  a_rxbuf_byte_wide: assert property (rd && apb_in.paddr == `UBAE_OFF_RXBUF |-> apb_out.prdata[31:8] == 24'h00_0000)
    else $error("receive buffer upper bits set");
  a_summary_follows: assert property (rd && apb_in.paddr == `UBAE_OFF_STAT && (apb_out.prdata[0] || apb_out.prdata[1]) |-> apb_out.prdata[4])
    else $error("summary flag missing");
  a_dormant_kept: assert property (rd && apb_in.paddr == `UBAE_OFF_CTRL |-> apb_out.prdata[`UBAE_C_DORM] == dorm_q)
    else $error("dormant bit changed by hardware");
endmodule
bind ubae_core ubae_core_chk ubae_core_chk_i (.clk_in(clk_in), .reset_n_in(reset_n_in), .apb_in(apb_in),
  .apb_out(apb_out), .rx_line_in(rx_line_in), .tx_line_out(tx_line_out));

// ==== test/ubae_remote.sv ====
// remote serial node: drives the receive line and captures the transmit line
`timescale 1ns/100ps
module ubae_remote #(
  parameter int BIT_CYC = 32
) (
  input  wire logic clk_in,
  input  wire logic line_in,
  output logic      line_out
);
  logic [8:0] rx_q[$];
  int         low_q[$];
  initial line_out = 1'b1;
  task automatic level(input logic v, input int n);
    @(posedge clk_in);
    line_out <= v;
    repeat (n * BIT_CYC - 1) @(posedge clk_in);
  endtask
  // lsb first; the line goes back to idle high even after a low stop bit
  task automatic char(input logic [7:0] d, input logic par_on, input logic par, input logic stop);
    level(1'b0, 1);
    for (int i = 0; i < 8; i++) level(d[i], 1);
    if (par_on) level(par, 1);
    level(stop, 1);
    @(posedge clk_in);
    line_out <= 1'b1;
  endtask
  // n low bits then two high delimiter bits; the receiver's bit timer lags by its deglitch time
  task automatic brk(input int n);
    level(1'b0, n);
    level(1'b1, 2);
  endtask
  // sample mid-bit; also time the first low run, which shows break length
  always begin : capture
    logic [8:0] f;
    int         low;
    int         c;
    @(negedge line_in);
    low = 0;
    f = '0;
    c = 0;
    while (c < 10 * BIT_CYC || low == 0) begin
      @(posedge clk_in);
      if (line_in === 1'b1 && low == 0) low = c + 1;
      if (c < 10 * BIT_CYC && c % BIT_CYC == BIT_CYC / 2 && c >= BIT_CYC) f[c / BIT_CYC - 1] = line_in;
      c++;
    end
    rx_q.push_back(f);
    low_q.push_back(low);
  end
endmodule

// ==== test/test_uart_break_autobaud_irda_errors.sv ====
// self-checking bench for the serial port against a remote node model
`timescale 1ns/100ps
`include "ubae_regs.svh"
module test_uart_break_autobaud_irda_errors;
  import ubae_pkg::*;
  localparam int BIT_CYC = 32;
  logic          clk_in;
  logic          reset_n_in;
  ubae_apb_req_t req;
  ubae_apb_rsp_t rsp;
  logic          rx_line;
  logic          tx_line;
  int            mismatches;
  int            checked;
  logic [7:0]    exp_q[$];
  logic [31:0]   rd_v;
  logic          rd_e;
  logic [7:0]    b;
  logic [31:0]   n_hi;
  ubae_core ubae_core_i (.clk_in(clk_in), .reset_n_in(reset_n_in), .apb_in(req), .apb_out(rsp),
    .rx_line_in(rx_line), .tx_line_out(tx_line));
  ubae_remote #(.BIT_CYC(BIT_CYC)) ubae_remote_i (.clk_in(clk_in), .line_in(tx_line), .line_out(rx_line));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // setup, access, hold until ready is sampled high, then release
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_in);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk_in);
    req.penable <= 1'b1;
    do begin
      @(posedge clk_in);
      n++;
    end while (rsp.pready !== 1'b1 && n < 50);
    rd_v = rsp.prdata;
    rd_e = rsp.pslverr;
    req <= '0;
    if (n >= 50) mismatches++;
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk($sformatf("reg %h", a), e, rd_v);
  endtask
  task automatic tx_chk(input logic [8:0] e, input int bits);
    int n;
    n = 0;
    while (ubae_remote_i.rx_q.size() == 0 && n < 9000) begin
      @(posedge clk_in);
      n++;
    end
    if (n >= 9000) mismatches++;
    else chk("tx frame", e, ubae_remote_i.rx_q.pop_front());
    if (n < 9000 && bits > 0) chk("tx low bits", bits, (ubae_remote_i.low_q.pop_front() + BIT_CYC / 2) / BIT_CYC);
    else if (n < 9000) void'(ubae_remote_i.low_q.pop_front());
  endtask
  // margin past the stop bit for the receive flags to land
  task automatic settle();
    repeat (BIT_CYC) @(posedge clk_in);
  endtask
  task automatic close_out();
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  initial begin
    repeat (60000) @(posedge clk_in);
    mismatches++;
    close_out();
  end
  initial begin
    reset_n_in = 1'b0;
    req = '0;
    mismatches = 0;
    checked = 0;
    void'($urandom(32'h125e_fd96));
    repeat (10) @(posedge clk_in);
    reset_n_in <= 1'b1;
    rd_chk(`UBAE_OFF_CTRL, 32'h0000_0001);
    rd_chk(`UBAE_OFF_BAUD, 32'h0000_0010);
    rd_chk(`UBAE_OFF_STAT, 32'h0000_0100);
    bus(1'b0, 12'h020, 32'h0000_0000);
    chk("unmapped error", 32'h0000_0001, {31'h0, rd_e});
    bus(1'b1, `UBAE_OFF_BAUD, 32'h0000_0002);
    bus(1'b1, `UBAE_OFF_CTRL, 32'h0000_0000);
    // overrun loaded after the status read survives the buffer read
    for (int i = 0; i < 2; i++) begin
      b = 8'($urandom);
      exp_q.push_back(b);
      ubae_remote_i.char(b, 1'b0, 1'b0, 1'b1);
      settle();
      if (i == 0) rd_chk(`UBAE_OFF_STAT, 32'h0000_0180);
    end
    void'(exp_q.pop_front());
    b = exp_q.pop_front();
    rd_chk(`UBAE_OFF_RXBUF, {24'h00_0000, b});
    rd_chk(`UBAE_OFF_STAT, 32'h0000_0104);
    rd_chk(`UBAE_OFF_RXBUF, {24'h00_0000, b});
    rd_chk(`UBAE_OFF_STAT, 32'h0000_0100);
    // parity on, odd; error characters loaded while enabled
    bus(1'b1, `UBAE_OFF_CTRL, 32'h0000_0208);
    for (int k = 0; k < 4; k++) begin
      b = 8'($urandom) | 8'h01;
      ubae_remote_i.char(b, 1'b1, ^b ^ (k < 2), k[0] == 1'b0);
      settle();
      rd_chk(`UBAE_OFF_STAT, 32'h0000_0180 | (k[0] ? 32'h0000_0011 : 0) | (k[1] ? 32'h0000_0012 : 0));
      rd_chk(`UBAE_OFF_RXBUF, {24'h00_0000, b});
    end
    rd_chk(`UBAE_OFF_STAT, 32'h0000_0100);
    bus(1'b1, `UBAE_OFF_CTRL, 32'h0000_0008);
    ubae_remote_i.char(8'h5a, 1'b1, 1'b1, 1'b0);
    settle();
    rd_chk(`UBAE_OFF_STAT, 32'h0000_0100);
    // all-low character in each plain mode; no address bit in this block
    for (int m = 0; m < 3; m++) begin
      bus(1'b1, `UBAE_OFF_CTRL, 32'h0000_0100 | (m << 1));
      ubae_remote_i.brk(10);
      settle();
      rd_chk(`UBAE_OFF_STAT, 32'h0000_0199);
      rd_chk(`UBAE_OFF_RXBUF, 32'h0000_0000);
    end
    bus(1'b1, `UBAE_OFF_CTRL, 32'h0000_0800);
    bus(1'b1, `UBAE_OFF_TXBUF, 32'h0000_0000);
    tx_chk(9'h000, 10);
    rd_chk(`UBAE_OFF_CTRL, 32'h0000_0000);
    b = 8'($urandom);
    bus(1'b1, `UBAE_OFF_TXBUF, {24'h00_0000, b});
    tx_chk({1'b1, b}, 0);
    bus(1'b1, `UBAE_OFF_CTRL, 32'h0000_0806);
    bus(1'b1, `UBAE_OFF_TXBUF, 32'h0000_0055);
    tx_chk(9'h000, 13);
    tx_chk(9'h155, 0);
    rd_chk(`UBAE_OFF_CTRL, 32'h0000_0006);
    // dormant auto-baud reception; nothing is written to transmit meanwhile
    for (int n = 13; n < 24; n += 10) begin
      bus(1'b1, `UBAE_OFF_STAT, 32'h0000_007f);
      bus(1'b1, `UBAE_OFF_BAUD, 32'h0005_0002);
      bus(1'b1, `UBAE_OFF_CTRL, 32'h0000_1506);
      b = 8'($urandom) | 8'h01;
      ubae_remote_i.char(b, 1'b0, 1'b0, 1'b1);
      settle();
      rd_chk(`UBAE_OFF_STAT, 32'h0000_0100);
      ubae_remote_i.brk(n);
      ubae_remote_i.char(8'h55, 1'b0, 1'b0, 1'b1);
      ubae_remote_i.char(b, 1'b0, 1'b0, 1'b1);
      settle();
      rd_chk(`UBAE_OFF_STAT, 32'h0000_0188 | (n > 21 ? 32'h0000_0020 : 0));
      rd_chk(`UBAE_OFF_BAUD, 32'h0000_0002);
      rd_chk(`UBAE_OFF_RXBUF, {24'h00_0000, b});
      rd_chk(`UBAE_OFF_CTRL, 32'h0000_1506);
    end
    // infrared transmit from the source clock: nine zero bits, four half clocks each
    bus(1'b1, `UBAE_OFF_BAUD, 32'h0000_0005);
    bus(1'b1, `UBAE_OFF_IRDA, 32'h0000_010d);
    bus(1'b1, `UBAE_OFF_TXBUF, 32'h0000_0000);
    n_hi = 32'h0000_0000;
    repeat (880) begin
      @(posedge clk_in);
      n_hi = n_hi + {31'h0, tx_line};
    end
    chk("ir pulse clocks", 9 * (3 + 1) / 2, n_hi);
    close_out();
  end
endmodule
